// [rtl/smcd_defines.vh]
// constants for the sbc mode command decoder
// assumes frames arrive as whole 16-bit words from an spi front end
// Behaviour
// - mode 0_1100..0_1111 selects lp regulator off, bit1 forced wake, bit0 sense
// - mode 1_xxxx selects lp regulator on, low bits wake, sense, cyclic int, wdog
// - pending wake-up flag makes device enter lp then wake at once
// - write 0x5C10 in lp regulator-on mode wakes device to normal request
// - global commands decode address bits 13-9 with bits 15-14, bit 8 set, bits 6-0 clear
// - random code protection enabled only in init, by misc setup bit 7
// - in normal mode 0x1D00 or 0x1D80 returns random code on miso bits 2-0
// - unprotected write 0x5C60 enters lp regulator off without sense or wake
// - 1D00 reports status, mode, random code; clears debug, leaves safe pin unchanged
// - 1D80 reports as 1D00 and turns safe pin off
// - DD00 reports mode, safe bit1, debug bit0; clears debug, leaves safe unchanged
// - DD80 reports as DD00, keeps debug, turns safe pin off
// - mode codes 00000 init, 00001 reprogram, 00010 normal req, 00011 normal
// - safe status bit reads zero while safe driver active, one when off
// - debug status bit reads one while debug mode active
// - mode register at address 01_110, mode in bits 7-3, inverted code 2-0
`ifndef SMCD_DEFINES_VH
`define SMCD_DEFINES_VH
`define SMCD_ADDR_MODE    5'h0E
`define SMCD_ADDR_MISC    5'h0D
`define SMCD_MISC_RND_BIT 7
`define SMCD_RW_WRITE     2'h1
`define SMCD_RW_GLB_A     2'h0
`define SMCD_RW_GLB_B     2'h3
`define SMCD_MODE_INIT    5'h00
`define SMCD_MODE_FLASH   5'h01
`define SMCD_MODE_NREQ    5'h02
`define SMCD_MODE_NORMAL  5'h03
`define SMCD_LPOFF_BASE   3'h3
`define SMCD_FIX_STATUS   8'h00
`define SMCD_RND_RESET    3'h5
`endif

// [rtl/smcd_lfsr.v]
// free-running 3-bit pseudo random source for the low-power entry code
// assumes one clock; never reaches the all-zero lock state
`timescale 1ns/1ps
`default_nettype none
module smcd_lfsr #(
  parameter [2:0] SEED = 3'h5
) (
  // clock and reset
  input  wire       i_clock,
  input  wire       i_rst_n,
  // code
  output reg  [2:0] o_code
);
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_code <= SEED;
    end else begin
      o_code <= {o_code[1:0], o_code[2] ^ o_code[1]};
    end
  end
endmodule
`default_nettype wire

// [rtl/smcd_top.v]
// mode register command decoder: low-power selection, random code guard,
// global read commands for mode, safe pin and debug state
// assumes i_frame_valid pulses once per complete 16-bit frame on i_clock
`timescale 1ns/1ps
`default_nettype none
`include "smcd_defines.vh"
module smcd_top (
  // clock and reset
  input  wire        i_clock,
  input  wire        i_rst_n,
  // decoded spi frame
  input  wire        i_frame_valid,
  input  wire [15:0] i_frame,
  // wake sources and fail-safe side
  input  wire        i_wake_flag_pending,
  input  wire        i_debug_entry,
  input  wire        i_safe_assert,
  input  wire        i_init_to_normal,
  // reply and state
  output reg  [15:0] o_miso_word,
  output reg         o_miso_valid,
  output reg  [4:0]  o_mode,
  output reg         o_lp_vdd_off,
  output reg         o_lp_vdd_on,
  output reg         o_forced_wakeup_enable,
  output reg         o_cyclic_sense_enable,
  output reg         o_cyclic_int_enable,
  output reg         o_lp_watchdog_enable,
  output reg         o_safe_pin_active,
  output reg         o_debug_active,
  output reg         o_random_protect,
  output reg         o_wake_event
);
  wire [2:0] rnd_code;
  reg        pend_s1;
  reg        pend_s2;
  reg        dbg_s1;
  reg        dbg_s2;
  reg        safe_s1;
  reg        safe_s2;
  reg        lp_wake_pending;
  wire [1:0] rw      = i_frame[15:14];
  wire [4:0] addr    = i_frame[13:9];
  wire       p_bit   = i_frame[8];
  wire [4:0] wmode   = i_frame[7:3];
  wire [2:0] wcode   = i_frame[2:0];
  wire       to_mode = i_frame_valid && addr == `SMCD_ADDR_MODE;
  wire       is_glb  = to_mode && p_bit && (rw == `SMCD_RW_GLB_A || rw == `SMCD_RW_GLB_B)
                       && i_frame[6:0] == 7'h00;
  wire       is_wr   = to_mode && rw == `SMCD_RW_WRITE;
  wire       is_lpoff = wmode[4:2] == `SMCD_LPOFF_BASE;
  wire       is_lpon  = wmode[4];
  wire       in_lp    = o_lp_vdd_off || o_lp_vdd_on;
  // protection compares against the inverse of the code taken at the last global command in normal mode
  reg  [2:0] last_code;
  wire       code_ok  = !o_random_protect || (wcode == ~last_code);
  wire       lp_req   = is_wr && (is_lpoff || is_lpon) && !in_lp
                        && o_mode == `SMCD_MODE_NORMAL;

  smcd_lfsr #(
    .SEED (`SMCD_RND_RESET)
  ) u_lfsr (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .o_code  (rnd_code)
  );

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      pend_s1 <= 1'b0;
      pend_s2 <= 1'b0;
      dbg_s1  <= 1'b0;
      dbg_s2  <= 1'b0;
      safe_s1 <= 1'b0;
      safe_s2 <= 1'b0;
    end else begin
      pend_s1 <= i_wake_flag_pending;
      pend_s2 <= pend_s1;
      dbg_s1  <= i_debug_entry;
      dbg_s2  <= dbg_s1;
      safe_s1 <= i_safe_assert;
      safe_s2 <= safe_s1;
    end
  end

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_mode                 <= `SMCD_MODE_INIT;
      o_lp_vdd_off           <= 1'b0;
      o_lp_vdd_on            <= 1'b0;
      o_forced_wakeup_enable <= 1'b0;
      o_cyclic_sense_enable  <= 1'b0;
      o_cyclic_int_enable    <= 1'b0;
      o_lp_watchdog_enable   <= 1'b0;
      o_random_protect       <= 1'b0;
      o_wake_event           <= 1'b0;
      lp_wake_pending        <= 1'b0;
      last_code              <= 3'h0;
    end else begin
      o_wake_event <= 1'b0;
      if (i_frame_valid && addr == `SMCD_ADDR_MISC && rw == `SMCD_RW_WRITE
          && o_mode == `SMCD_MODE_INIT) begin
        o_random_protect <= i_frame[`SMCD_MISC_RND_BIT];
      end
      if (o_mode == `SMCD_MODE_INIT && i_init_to_normal) begin
        o_mode <= `SMCD_MODE_NORMAL;
      end
      if (is_glb && o_mode == `SMCD_MODE_NORMAL) begin
        last_code <= rnd_code;
      end
      if (lp_req && code_ok) begin
        o_mode          <= wmode;
        lp_wake_pending <= pend_s2;
        if (is_lpon) begin
          o_lp_vdd_on            <= 1'b1;
          o_forced_wakeup_enable <= wmode[3];
          o_cyclic_sense_enable  <= wmode[2];
          o_cyclic_int_enable    <= wmode[1];
          o_lp_watchdog_enable   <= wmode[0];
        end else begin
          o_lp_vdd_off           <= 1'b1;
          o_forced_wakeup_enable <= wmode[1];
          o_cyclic_sense_enable  <= wmode[0];
          o_cyclic_int_enable    <= 1'b0;
          o_lp_watchdog_enable   <= 1'b0;
        end
      end else if (in_lp && (lp_wake_pending || pend_s2
                   || (o_lp_vdd_on && is_wr && wmode == `SMCD_MODE_NREQ))) begin
        o_mode                 <= `SMCD_MODE_NREQ;
        o_lp_vdd_off           <= 1'b0;
        o_lp_vdd_on            <= 1'b0;
        o_forced_wakeup_enable <= 1'b0;
        o_cyclic_sense_enable  <= 1'b0;
        o_cyclic_int_enable    <= 1'b0;
        o_lp_watchdog_enable   <= 1'b0;
        o_wake_event           <= 1'b1;
        lp_wake_pending        <= 1'b0;
      end else if (o_mode == `SMCD_MODE_NREQ && is_wr && wmode == `SMCD_MODE_NORMAL) begin
        o_mode <= `SMCD_MODE_NORMAL;
      end
    end
  end

  // safe pin and debug: set from the fail-safe side wins over a clear
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_safe_pin_active <= 1'b0;
      o_debug_active    <= 1'b0;
    end else begin
      if (safe_s2) begin
        o_safe_pin_active <= 1'b1;
      end else if (is_glb && i_frame[7]) begin
        o_safe_pin_active <= 1'b0;
      end
      if (dbg_s2) begin
        o_debug_active <= 1'b1;
      end else if (is_glb && !i_frame[7]) begin
        o_debug_active <= 1'b0;
      end
    end
  end

  // reply word, mode in 7-3 per register layout
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_miso_word  <= 16'h0000;
      o_miso_valid <= 1'b0;
    end else begin
      o_miso_valid <= is_glb;
      if (is_glb) begin
        if (rw == `SMCD_RW_GLB_A) begin
          o_miso_word <= {`SMCD_FIX_STATUS, o_mode, rnd_code};
        end else begin
          o_miso_word <= {`SMCD_FIX_STATUS, o_mode, 1'b0, ~o_safe_pin_active,
                          o_debug_active};
        end
      end
    end
  end
endmodule
`default_nettype wire

// [tb/smcd_host.sv]
// host model: spi master handing whole frames to the decoder
// assumes the bench calls its tasks; frames change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module smcd_host (
  input  wire logic        i_clock,
  output var  logic        o_valid,
  output var  logic [15:0] o_frame
);
  initial begin
    o_valid = 1'h0;
    o_frame = 16'hFFFF;
  end
  task send(input logic [15:0] f);
    @(posedge i_clock);
    o_valid <= 1'h1;
    o_frame <= f;
    @(posedge i_clock);
    o_valid <= 1'h0;
    o_frame <= ~f; // released word never repeats the last frame
    // reply and state stand from the taking edge on; return while they do
    #1;
  endtask
  task lp_req(input logic [4:0] m, input logic [2:0] c);
    send(16'hE100);
    send(16'hE380);
    send(16'hE700);
    send(16'hE900);
    send(16'hE180);
    send({8'h5C, m, c});
  endtask
endmodule
`default_nettype wire

// [tb/smcd_properties.sv]
// port checker for the mode command decoder
// assumes bind onto smcd_top, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module smcd_properties (
  input wire logic        i_clock, i_rst_n, i_frame_valid, i_debug_entry, i_safe_assert,
  input wire logic [15:0] i_frame, o_miso_word,
  input wire logic [4:0]  o_mode,
  input wire logic        o_miso_valid, o_lp_vdd_off, o_lp_vdd_on, o_forced_wakeup_enable,
  input wire logic        o_cyclic_sense_enable, o_cyclic_int_enable, o_lp_watchdog_enable,
  input wire logic        o_safe_pin_active, o_debug_active, o_wake_event
);
  wire t  = i_frame_valid;
  wire g  = t && i_frame[15] == i_frame[14] && i_frame[13:8] == 6'h1D && i_frame[6:0] == 7'h0;
  wire g0 = g && !i_frame[7];
  wire g1 = g && i_frame[7];
  wire dd = i_frame[15];
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  chk_reply_pulse: assert property (g |=> o_miso_valid) else $error("no reply");
  chk_reply_mode: assert property (g |=> o_miso_word[7:3] == $past(o_mode))
    else $error("mode");
  chk_safe_bit: assert property (g0 && dd |=> o_miso_word[1] != $past(o_safe_pin_active))
    else $error("safe bit");
  chk_debug_bit: assert property (g1 && dd |=> o_miso_word[0] == $past(o_debug_active))
    else $error("debug bit");
  chk_debug_leave: assert property (g0 && !i_debug_entry |=> !o_debug_active)
    else $error("debug kept");
  chk_safe_off: assert property (g1 && !i_safe_assert |=> !o_safe_pin_active)
    else $error("safe kept");
  chk_lp_off: assert property (o_lp_vdd_off |-> o_mode[4:2] == 3'h3 &&
    {o_forced_wakeup_enable, o_cyclic_sense_enable} == o_mode[1:0]) else $error("lp off");
  chk_lp_on: assert property (o_lp_vdd_on |-> o_mode[4] && {o_forced_wakeup_enable,
    o_cyclic_sense_enable, o_cyclic_int_enable, o_lp_watchdog_enable} == o_mode[3:0])
    else $error("lp on");
  chk_spi_wake: assert property (t && i_frame == 16'h5C10 && o_lp_vdd_on
    |=> o_mode == 5'h02 && o_wake_event) else $error("wake");
endmodule
bind smcd_top smcd_properties i_chk (.*);
`default_nettype wire

// [tb/smcd_top_tb_top.sv]
// bench for the mode command decoder with hand-written scenarios
// assumes smcd_host drives frames; bench drives reset and side inputs
`timescale 1ns/1ps
`default_nettype none
module smcd_top_tb_top;
  logic        clk, rst_n, wake, dbg, safe, norm, fv;
  logic [15:0] fr, word;
  logic [4:0]  mode;
  logic        mv, off, on, fw, cs, ci, wd, sp, dba, rp, we;
  int          n_fail, check_count;
  smcd_host i_host (.i_clock(clk), .o_valid(fv), .o_frame(fr));
  smcd_top i_dut (.i_clock(clk), .i_rst_n(rst_n), .i_frame_valid(fv), .i_frame(fr),
    .i_wake_flag_pending(wake), .i_debug_entry(dbg), .i_safe_assert(safe),
    .i_init_to_normal(norm), .o_miso_word(word), .o_miso_valid(mv), .o_mode(mode),
    .o_lp_vdd_off(off), .o_lp_vdd_on(on), .o_forced_wakeup_enable(fw),
    .o_cyclic_sense_enable(cs), .o_cyclic_int_enable(ci), .o_lp_watchdog_enable(wd),
    .o_safe_pin_active(sp), .o_debug_active(dba), .o_random_protect(rp), .o_wake_event(we));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task start(input logic to_nrm);
    @(posedge clk);
    rst_n <= 0;
    repeat (8) @(posedge clk);
    rst_n <= 1;
    norm <= to_nrm;
    repeat (2) @(posedge clk);
    norm <= 0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task t_init_status;
    start(0);
    i_host.send(16'hDD00);
    chk(mv, 1);
    chk(word, 16'h0002);
  endtask
  task t_wake_pending;
    start(1);
    wake <= 1;
    i_host.lp_req(5'h0C, 3'h0);
    for (int i = 0; i < 8 && we !== 1'h1; i++) begin
      @(posedge clk);
      #1;
    end
    chk({we, mode}, {1'h1, 5'h02});
    wake <= 0;
    i_host.send(16'h5C18);
    i_host.lp_req(5'h0C, 3'h0);
    chk({off, fw, cs, mode}, {3'h4, 5'h0C});
  endtask
  task t_lp_on;
    logic [4:0] m;
    start(1);
    m = 5'h10;
    for (int i = 0; i < 4; i++) begin
      i_host.lp_req(m, 3'h0);
      chk({on, fw, cs, ci, wd}, {1'h1, m[3:0]});
      i_host.send(16'h5C10);
      chk({we, mode}, {1'h1, 5'h02});
      i_host.send(16'h5C18);
      m = m + 5'h5;
    end
  endtask
  task t_random_code;
    logic [2:0] c;
    start(0);
    i_host.send(16'h5B80);
    chk(rp, 1);
    // leave init without a reset so the protection bit survives
    @(posedge clk);
    norm <= 1;
    @(posedge clk);
    norm <= 0;
    @(posedge clk);
    #1;
    chk({rp, mode}, {1'h1, 5'h03});
    i_host.send(16'h1D80);
    c = word[2:0];
    chk(word[15:3], {8'h00, 5'h03});
    i_host.lp_req(5'h0C, ~c ^ 3'h1);
    chk(mode, 5'h03);
    i_host.lp_req(5'h0C, ~c);
    chk(mode, 5'h0C);
  endtask
  task t_safe_debug;
    start(1);
    safe <= 1;
    repeat (4) @(posedge clk);
    i_host.send(16'hDD00);
    chk(word, 16'h0018);
    safe <= 0;
    dbg <= 1;
    repeat (4) @(posedge clk);
    dbg <= 0;
    repeat (4) @(posedge clk);
    i_host.send(16'h1D80);
    chk({sp, dba}, 2'h1);
    i_host.send(16'hDD80);
    chk({word, dba}, {16'h001B, 1'h1});
    i_host.send(16'h1D00);
    chk({word[15:3], dba}, {8'h00, 5'h03, 1'h0});
  endtask
  initial begin
    rst_n = 0;
    wake = 0;
    dbg = 0;
    safe = 0;
    norm = 0;
    n_fail = 0;
    check_count = 0;
    t_init_status;
    t_wake_pending;
    t_lp_on;
    t_random_code;
    t_safe_debug;
    finish_test;
  end
  initial begin
    #400000;
    n_fail++;
    finish_test;
  end
endmodule
`default_nettype wire
